// ===== sram_link_pkg.sv
// Shared constants of the two-beat burst memory link
package sram_link_pkg;
  localparam int LANE_W      = 9;
  localparam int DEV_WIDTH   = 36;
  localparam int DEV_ADDR_W  = 19;
  localparam int CLK_MHZ     = 200;
  localparam int INIT_US     = 20;
  localparam int INIT_CYC    = INIT_US * CLK_MHZ;
  localparam int PLL_MIN_MHZ = 120;
  localparam int K_HALF_CYC  = 8;
  localparam int MIN_K_HALF  = 8;
  localparam int CLK_PINS    = 4;
  localparam int PIN_K       = 0;
  localparam int PIN_KN      = 1;
  localparam int PIN_C       = 2;
  localparam int PIN_CN      = 3;

  typedef enum logic [1:0] {
    CT_INIT = 2'b00,
    CT_RUN  = 2'b01,
    CT_PARK = 2'b10
  } ctl_state_t;
endpackage

// ===== sram_link_if.sv
// Pin-level link between memory controller and burst memory device
`timescale 1ns/1ps
interface sram_link_if #(
  parameter int WIDTH  = 36,
  parameter int ADDR_W = 19
);
  localparam int LANES = WIDTH / 9;

  logic              k;
  logic              k_n;
  logic              c;
  logic              c_n;
  logic              access_load_strobe_n;
  logic              rw;
  logic [ADDR_W-1:0] word_address_in;
  logic [LANES-1:0]  byte_lane_write_n;
  logic              pll_bypass_n;
  logic [WIDTH-1:0]  ctl_dq_out;
  logic              ctl_dq_oe;
  logic [WIDTH-1:0]  dev_dq_out;
  logic              dev_dq_oe;
  logic [WIDTH-1:0]  dq;
  logic              echo_strobe;
  logic              echo_strobe_n;

  // Resolved bus level; an undriven bus reads as zero
  assign dq = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : '0);

  modport device (
    input  k, k_n, c, c_n, access_load_strobe_n, rw, word_address_in,
    input  byte_lane_write_n, pll_bypass_n, dq,
    output dev_dq_out, dev_dq_oe, echo_strobe, echo_strobe_n
  );

  modport ctrl (
    output k, k_n, c, c_n, access_load_strobe_n, rw, word_address_in,
    output byte_lane_write_n, pll_bypass_n, ctl_dq_out, ctl_dq_oe,
    input  dq, echo_strobe, echo_strobe_n
  );
endinterface

// ===== burst_sram_controller.sv
// Memory controller end: makes the link clocks, issues commands, collects reads
`timescale 1ns/1ps
module burst_sram_controller
  import sram_link_pkg::*;
#(
  parameter int WIDTH     = DEV_WIDTH,
  parameter int ADDR_W    = DEV_ADDR_W,
  parameter int K_HALF    = K_HALF_CYC,
  parameter int INIT_LEN  = INIT_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  sram_link_if.ctrl                   link,
  input  wire logic                   double_clock,
  input  wire logic                   clock_stop,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire logic                   req_write,
  input  wire logic [ADDR_W-1:0]      req_addr,
  input  wire logic [WIDTH-1:0]       req_wdata0,
  input  wire logic [WIDTH-1:0]       req_wdata1,
  input  wire logic [WIDTH/9-1:0]     req_lane_n0,
  input  wire logic [WIDTH/9-1:0]     req_lane_n1,
  output logic                        resp_valid,
  output logic [WIDTH-1:0]            resp_data0,
  output logic [WIDTH-1:0]            resp_data1,
  output logic                        init_done
);
  localparam int LANES  = WIDTH / LANE_W;
  localparam int PERIOD = 2 * K_HALF;
  localparam int PH_W   = $clog2(PERIOD);
  localparam int INIT_W = $clog2(INIT_LEN + 1);
  localparam logic [PH_W-1:0] PH_RISE   = '0;
  localparam logic [PH_W-1:0] PH_HALF   = PH_W'(K_HALF);
  localparam logic [PH_W-1:0] PH_MID_HI = PH_W'(K_HALF / 2);
  localparam logic [PH_W-1:0] PH_MID_LO = PH_W'(PERIOD - K_HALF / 2);
  localparam logic [PH_W-1:0] PH_LAST   = PH_W'(PERIOD - 1);
  localparam logic PLL_USED = (CLK_MHZ / PERIOD) >= PLL_MIN_MHZ;

  if (K_HALF < MIN_K_HALF || K_HALF % 2 != 0) $error("K_HALF must be even and at least MIN_K_HALF");
  if (WIDTH != 2 * LANE_W && WIDTH != 4 * LANE_W) $error("WIDTH must be 18 or 36");
  if (INIT_LEN < 1) $error("INIT_LEN must be positive");

  typedef struct packed {
    ctl_state_t          state;
    logic [PH_W-1:0]     phase;
    logic [INIT_W-1:0]   init_cnt;
    logic                mode;
    logic                k;
    logic                ld_n;
    logic                rw;
    logic [ADDR_W-1:0]   addr;
    logic [LANES-1:0]    bw_n;
    logic [WIDTH-1:0]    dq;
    logic                dq_oe;
    logic                pend_wr;
    logic [WIDTH-1:0]    pend_wd0;
    logic [WIDTH-1:0]    pend_wd1;
    logic [LANES-1:0]    pend_bw0;
    logic [LANES-1:0]    pend_bw1;
    logic [WIDTH-1:0]    cur_wd1;
    logic [LANES-1:0]    cur_bw1;
    logic                last_rd;
    logic [2:0]          rd_pipe;
    logic                echo_s1;
    logic                echo_s2;
    logic                echo_q;
    logic                echon_s1;
    logic                echon_s2;
    logic                echon_q;
    logic [WIDTH-1:0]    dq_s1;
    logic [WIDTH-1:0]    dq_s2;
    logic                resp_valid;
    logic [WIDTH-1:0]    resp_d0;
    logic [WIDTH-1:0]    resp_d1;
  } ctl_s_t;

  ctl_s_t s;
  ctl_s_t next_s;
  logic   cmd_ok;
  logic   accept;
  logic   idle;

  always_comb begin
    next_s = s;
    next_s.resp_valid = 1'b0;
    cmd_ok = (s.state == CT_RUN) && (s.phase == PH_MID_LO) && (s.mode == double_clock);
    // Turnaround: a write right after a read would collide with both read beats
    req_ready = cmd_ok && !(req_write && s.last_rd);
    accept = req_valid && req_ready;
    idle = s.ld_n && !s.pend_wr && !s.dq_oe && (s.rd_pipe == 3'h0);

    if (s.state != CT_PARK) begin
      next_s.phase = (s.phase == PH_LAST) ? PH_RISE : s.phase + PH_W'(1);
    end
    next_s.k = next_s.phase < PH_HALF;

    case (s.state)
      CT_INIT: begin
        next_s.init_cnt = s.init_cnt + INIT_W'(1);
        if (s.init_cnt == INIT_W'(INIT_LEN - 1)) begin
          next_s.state = CT_RUN;
        end
      end
      CT_RUN: begin
        // Park at K high, K# low: the complementary rest levels
        if (clock_stop && idle && s.phase == PH_LAST) begin
          next_s.state = CT_PARK;
        end
      end
      CT_PARK: begin
        if (!clock_stop) begin
          next_s.state = CT_RUN;
        end
      end
      default: next_s.state = CT_INIT;
    endcase

    // Clock mode change needs the full settling period again
    if (s.mode != double_clock) begin
      next_s.mode = double_clock;
      next_s.state = CT_INIT;
      next_s.init_cnt = '0;
    end

    if (s.phase == PH_RISE && s.state != CT_PARK) begin
      next_s.rd_pipe = {s.rd_pipe[1:0], !s.ld_n && s.rw};
    end

    // Second write beat half a cycle later, lanes chosen per beat
    if (s.phase == PH_MID_HI && s.dq_oe) begin
      next_s.dq = s.cur_wd1;
      next_s.bw_n = s.cur_bw1;
    end

    if (s.phase == PH_MID_LO) begin
      // Commands change mid low phase, clear of the K rise
      next_s.dq = s.pend_wd0;
      next_s.bw_n = s.pend_wr ? s.pend_bw0 : '1;
      next_s.dq_oe = s.pend_wr;
      next_s.cur_wd1 = s.pend_wd1;
      next_s.cur_bw1 = s.pend_bw1;
      next_s.ld_n = !accept;
      next_s.pend_wr = accept && req_write;
      next_s.last_rd = accept && !req_write;
      if (accept) begin
        next_s.rw = !req_write;
        next_s.addr = req_addr;
        next_s.pend_wd0 = req_wdata0;
        next_s.pend_wd1 = req_wdata1;
        next_s.pend_bw0 = req_lane_n0;
        next_s.pend_bw1 = req_lane_n1;
      end
    end

    next_s.echo_s1 = link.echo_strobe;
    next_s.echo_s2 = s.echo_s1;
    next_s.echo_q = s.echo_s2;
    next_s.echon_s1 = link.echo_strobe_n;
    next_s.echon_s2 = s.echon_s1;
    next_s.echon_q = s.echon_s2;
    next_s.dq_s1 = link.dq;
    next_s.dq_s2 = s.dq_s1;
    if (s.echon_s2 && !s.echon_q && s.rd_pipe[1]) begin
      next_s.resp_d0 = s.dq_s2;
    end
    if (s.echo_s2 && !s.echo_q && s.rd_pipe[2]) begin
      next_s.resp_d1 = s.dq_s2;
      next_s.resp_valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.ld_n <= 1'b1;
      s.bw_n <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign link.k = s.k;
  assign link.k_n = ~s.k;
  assign link.c = s.mode ? s.k : 1'b1;
  assign link.c_n = s.mode ? ~s.k : 1'b1;
  assign link.access_load_strobe_n = s.ld_n;
  assign link.rw = s.rw;
  assign link.word_address_in = s.addr;
  assign link.byte_lane_write_n = s.bw_n;
  assign link.pll_bypass_n = PLL_USED;
  assign link.ctl_dq_out = s.dq;
  assign link.ctl_dq_oe = s.dq_oe;
  assign resp_valid = s.resp_valid;
  assign resp_data0 = s.resp_d0;
  assign resp_data1 = s.resp_d1;
  assign init_done = (s.state != CT_INIT);
endmodule // burst_sram_controller

// ===== burst_sram_device.sv
// Device end: burst memory core behind the double-rate link
`timescale 1ns/1ps
module burst_sram_device
  import sram_link_pkg::*;
#(
  parameter int WIDTH  = DEV_WIDTH,
  parameter int ADDR_W = DEV_ADDR_W
) (
  input  wire logic clk,
  input  wire logic rst_n,
  sram_link_if.device link,
  output logic      out_clocks_tied,
  output logic      read_driving
);
  localparam int LANES = WIDTH / LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  if (WIDTH != 2 * LANE_W && WIDTH != 4 * LANE_W) $error("WIDTH must be 18 or 36");
  if (ADDR_W < 2 || ADDR_W > 24) $error("ADDR_W out of range");

  typedef logic [WIDTH-1:0]  word_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [LANES-1:0]  lane_t;

  typedef struct packed {
    logic [CLK_PINS-1:0] clk_s1;
    logic [CLK_PINS-1:0] clk_s2;
    logic [CLK_PINS-1:0] clk_q;
    logic                ld_n_s1;
    logic                ld_n_s2;
    logic                rw_s1;
    logic                rw_s2;
    addr_t               addr_s1;
    addr_t               addr_s2;
    lane_t               bw_n_s1;
    lane_t               bw_n_s2;
    word_t               dq_s1;
    word_t               dq_s2;
    addr_t               load_addr;
    logic                wr_a;
    logic                wr_b;
    addr_t               wr_addr_b;
    logic                rd_a;
    logic                rd_b;
    word_t               rd0;
    word_t               rd1;
    logic                beat1_due;
    word_t               q;
    logic                q_oe;
    logic                echo;
  } dev_s_t;

  dev_s_t s;
  dev_s_t next_s;
  word_t  mem [DEPTH];
  logic   mem_we;
  addr_t  mem_waddr;
  word_t  mem_wdata;
  logic   k_rise;
  logic   kn_rise;
  logic   tied;
  logic   oc_rise;
  logic   ocn_rise;

  // Partner word of a burst: only the lowest bit differs
  function automatic addr_t burst_partner(input addr_t a);
    burst_partner = {a[ADDR_W-1:1], ~a[0]};
  endfunction

  // Keep lanes whose strobe is high, take new data where low
  function automatic word_t merge_lanes(input word_t old_w, input word_t new_w, input lane_t bw_n);
    merge_lanes = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!bw_n[i]) begin
        merge_lanes[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
  endfunction

  always_comb begin
    next_s = s;
    mem_we = 1'b0;
    mem_waddr = s.load_addr;
    mem_wdata = '0;

    // Edges are found on the synchronised copies; no edge means no change
    k_rise = s.clk_s2[PIN_K] && !s.clk_q[PIN_K];
    kn_rise = s.clk_s2[PIN_KN] && !s.clk_q[PIN_KN];
    tied = s.clk_s2[PIN_C] && s.clk_s2[PIN_CN];
    oc_rise = tied ? k_rise : (s.clk_s2[PIN_C] && !s.clk_q[PIN_C]);
    ocn_rise = tied ? kn_rise : (s.clk_s2[PIN_CN] && !s.clk_q[PIN_CN]);

    next_s.clk_s1 = {link.c_n, link.c, link.k_n, link.k};
    next_s.clk_s2 = s.clk_s1;
    next_s.clk_q = s.clk_s2;
    next_s.ld_n_s1 = link.access_load_strobe_n;
    next_s.ld_n_s2 = s.ld_n_s1;
    next_s.rw_s1 = link.rw;
    next_s.rw_s2 = s.rw_s1;
    next_s.addr_s1 = link.word_address_in;
    next_s.addr_s2 = s.addr_s1;
    next_s.bw_n_s1 = link.byte_lane_write_n;
    next_s.bw_n_s2 = s.bw_n_s1;
    next_s.dq_s1 = link.dq;
    next_s.dq_s2 = s.dq_s1;

    // Echo follows the chosen output clock, with or without data
    next_s.echo = tied ? s.clk_s2[PIN_K] : s.clk_s2[PIN_C];

    if (k_rise) begin
      if (s.wr_a) begin
        mem_we = 1'b1;
        mem_waddr = s.load_addr;
        mem_wdata = merge_lanes(mem[s.load_addr], s.dq_s2, s.bw_n_s2);
      end
      next_s.wr_b = s.wr_a;
      next_s.wr_addr_b = burst_partner(s.load_addr);
      next_s.rd_b = s.rd_a;
      if (s.rd_a) begin
        next_s.rd0 = mem[s.load_addr];
        next_s.rd1 = mem[burst_partner(s.load_addr)];
      end
      // A new access may load every K cycle; the burst itself never grows
      next_s.wr_a = !s.ld_n_s2 && !s.rw_s2;
      next_s.rd_a = !s.ld_n_s2 && s.rw_s2;
      if (!s.ld_n_s2) begin
        next_s.load_addr = s.addr_s2;
      end
    end

    if (kn_rise && s.wr_b) begin
      mem_we = 1'b1;
      mem_waddr = s.wr_addr_b;
      mem_wdata = merge_lanes(mem[s.wr_addr_b], s.dq_s2, s.bw_n_s2);
      next_s.wr_b = 1'b0;
    end

    // First read beat on the complement output clock, second on the true one
    if (ocn_rise) begin
      if (s.rd_b) begin
        next_s.q = s.rd0;
        next_s.q_oe = 1'b1;
        next_s.beat1_due = 1'b1;
        next_s.rd_b = 1'b0;
      end else begin
        next_s.q_oe = 1'b0;
        next_s.beat1_due = 1'b0;
      end
    end
    if (oc_rise) begin
      if (s.beat1_due) begin
        next_s.q = s.rd1;
        next_s.beat1_due = 1'b0;
      end else begin
        next_s.q_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Memory content has no reset, as in the real array
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  assign link.dev_dq_out = s.q;
  assign link.dev_dq_oe = s.q_oe;
  assign link.echo_strobe = s.echo;
  assign link.echo_strobe_n = ~s.echo;
  assign out_clocks_tied = s.clk_q[PIN_C] && s.clk_q[PIN_CN];
  assign read_driving = s.q_oe;
endmodule // burst_sram_device

// ===== sram_link_properties.sv
// Pin-level checker of the burst memory link
`timescale 1ns/1ps
module sram_link_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic access_load_strobe_n,
  input wire logic rw,
  input wire logic dev_dq_oe,
  input wire logic ctl_dq_oe,
  input wire logic echo_strobe,
  input wire logic echo_strobe_n
);
  logic       k_q;
  logic [2:0] rises;
  wire        k_rise = k && !k_q;
  wire        tied   = c && c_n;
  wire        src    = tied ? k : c;
  wire        rd_ld  = k_rise && !access_load_strobe_n && rw;
  wire        wr_ld  = k_rise && !access_load_strobe_n && !rw;

  // Counts k rises only, so a parked link cannot age a pending read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      k_q   <= 1'b0;
      rises <= 3'h7;
    end else begin
      k_q <= k;
      if (rd_ld)
        rises <= 3'h0;
      else if (k_rise && rises != 3'h7)
        rises <= rises + 3'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_k_pair; k_n == !k; endproperty
  a_k_pair: assert property (p_k_pair)
    else $error("k pair not complementary");
  property p_c_pair; (c != c_n) || tied; endproperty
  a_c_pair: assert property (p_c_pair)
    else $error("c pair neither complementary nor tied");
  property p_echo_pair; echo_strobe_n == !echo_strobe; endproperty
  a_echo_pair: assert property (p_echo_pair)
    else $error("echo pair not complementary");
  property p_no_clash; !(dev_dq_oe && ctl_dq_oe); endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data bus");
  property p_read_oe; rd_ld |-> ##[20:40] dev_dq_oe; endproperty
  a_read_oe: assert property (p_read_oe)
    else $error("read data not driven in time");
  property p_oe_cause; dev_dq_oe |-> rises <= 3'h3; endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("data bus driven without a read");
  property p_two_beats; $rose(dev_dq_oe) |-> dev_dq_oe[*8] ##1 dev_dq_oe[*8]; endproperty
  a_two_beats: assert property (p_two_beats)
    else $error("read burst shorter than two beats");
  property p_write_oe; wr_ld |-> ##[1:16] ctl_dq_oe; endproperty
  a_write_oe: assert property (p_write_oe)
    else $error("write data not driven after load");
  property p_echo_run; $changed(src) && $stable(tied) |-> ##[1:6] $changed(echo_strobe); endproperty
  a_echo_run: assert property (p_echo_run)
    else $error("echo strobe does not follow its clock");
  // First read beat leaves on the complement edge, so the echo falls with it
  property p_echo_align; $rose(dev_dq_oe) |-> $fell(echo_strobe); endproperty
  a_echo_align: assert property (p_echo_align)
    else $error("echo strobe not aligned with read data");

  c_read: cover property (rd_ld);
  c_write: cover property (wr_ld);
  c_park: cover property ($stable(k) [*8] ##1 $stable(k));
  c_tied_read: cover property (tied && k_rise && dev_dq_oe);
endmodule // sram_link_properties

// ===== testbench.sv
// Bench joining controller and device across the link
`timescale 1ns/1ps
module testbench import sram_link_pkg::*;;
  localparam int AW  = DEV_ADDR_W;
  localparam int W   = DEV_WIDTH;
  localparam int LN  = DEV_WIDTH / LANE_W;
  localparam int INI = 20;

  logic           clk;
  logic           rst_n;
  logic           double_clock;
  logic           clock_stop;
  logic           req_valid;
  logic           req_ready;
  logic           req_write;
  logic [AW-1:0]  req_addr;
  logic [W-1:0]   req_wdata0;
  logic [W-1:0]   req_wdata1;
  logic [LN-1:0]  req_lane_n0;
  logic [LN-1:0]  req_lane_n1;
  logic           resp_valid;
  logic [W-1:0]   resp_data0;
  logic [W-1:0]   resp_data1;
  logic           init_done;
  logic           out_clocks_tied;
  logic           read_driving;
  int             miscompares;
  int             num_checks;
  logic [W-1:0]   mem [logic [AW-1:0]];
  logic [2*W-1:0] exp_q [$];
  logic [AW-1:0]  addr [8];

  sram_link_if #(.WIDTH(W), .ADDR_W(AW)) link ();
  burst_sram_controller #(.INIT_LEN(INI)) i_burst_sram_controller (.clk(clk), .rst_n(rst_n), .link(link),
    .double_clock(double_clock), .clock_stop(clock_stop), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata0(req_wdata0), .req_wdata1(req_wdata1),
    .req_lane_n0(req_lane_n0), .req_lane_n1(req_lane_n1), .resp_valid(resp_valid),
    .resp_data0(resp_data0), .resp_data1(resp_data1), .init_done(init_done));
  burst_sram_device i_burst_sram_device (.clk(clk), .rst_n(rst_n), .link(link),
    .out_clocks_tied(out_clocks_tied), .read_driving(read_driving));
  sram_link_properties i_sram_link_properties (.clk(clk), .rst_n(rst_n), .k(link.k), .k_n(link.k_n),
    .c(link.c), .c_n(link.c_n), .access_load_strobe_n(link.access_load_strobe_n), .rw(link.rw),
    .dev_dq_oe(link.dev_dq_oe), .ctl_dq_oe(link.ctl_dq_oe), .echo_strobe(link.echo_strobe),
    .echo_strobe_n(link.echo_strobe_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      $display("[FAIL] %0t %s", $time, msg);
      miscompares++;
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [W-1:0] merge(logic [W-1:0] old, logic [W-1:0] d, logic [LN-1:0] ln);
    for (int i = 0; i < LN; i++)
      if (!ln[i])
        old[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    return old;
  endfunction

  function automatic logic [W-1:0] rnd_word();
    logic [63:0] r;
    r = {$urandom(), $urandom()};
    return r[W-1:0];
  endfunction

  // Expectations are noted at acceptance; answers come back in request order
  task automatic req(input logic wr, input logic [AW-1:0] a, input logic [LN-1:0] l0, input logic [LN-1:0] l1);
    logic [AW-1:0] b;
    int            n;
    b = a ^ AW'(1);
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata0 = rnd_word();
    req_wdata1 = rnd_word();
    req_lane_n0 = l0;
    req_lane_n1 = l1;
    #1;
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(n < 200, "request not accepted");
    if (wr) begin
      mem[a] = merge(mem[a], req_wdata0, l0);
      mem[b] = merge(mem[b], req_wdata1, l1);
    end else
      exp_q.push_back({mem[a], mem[b]});
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(n < 400, "read answer missing");
    repeat (20) @(negedge clk);
  endtask

  task automatic wait_init(input int lo);
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
      check(link.access_load_strobe_n === 1'b1 && read_driving === 1'b0, "bus activity in init");
    end
    check(n >= lo && n < 5000, "init length wrong");
  endtask

  always @(negedge clk) begin
    if (rst_n && resp_valid === 1'b1) begin
      if (exp_q.size() == 0)
        check(1'b0, "unexpected read answer");
      else
        check({resp_data0, resp_data1} === exp_q.pop_front(), "read data mismatch");
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    logic [31:0] base;
    logic        kp;
    rst_n = 1'b0;
    double_clock = 1'b0;
    clock_stop = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata0 = '0;
    req_wdata1 = '0;
    req_lane_n0 = '1;
    req_lane_n1 = '1;
    miscompares = 0;
    num_checks = 0;
    base = $urandom(20477);
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    wait_init(INI);
    check(link.pll_bypass_n === 1'b0, "bypass level wrong");
    check(out_clocks_tied === 1'b1, "tied output clocks not seen");
    base = $urandom();
    for (int i = 0; i < 8; i++)
      addr[i] = {base[AW-1:4], i[2:0], base[i]};
    for (int i = 0; i < 8; i++)
      req(1'b1, addr[i], '0, '0);
    for (int i = 0; i < 8; i++)
      req(1'b0, addr[7-i], LN'($urandom()), LN'($urandom()));
    for (int i = 0; i < 16; i++)
      req(1'b1, addr[i%8], LN'(i), LN'(15-i));
    for (int i = 0; i < 12; i++)
      req(1'($urandom_range(1)), addr[$urandom_range(7)], LN'($urandom()), LN'($urandom()));
    drain();
    clock_stop = 1'b1;
    repeat (60) @(negedge clk);
    kp = link.k;
    repeat (40) @(negedge clk);
    check(link.k === kp && kp === 1'b1 && read_driving === 1'b0, "clocks not parked");
    clock_stop = 1'b0;
    for (int i = 0; i < 8; i++)
      req(1'b0, addr[i], '0, '0);
    drain();
    double_clock = 1'b1;
    repeat (4) @(negedge clk);
    wait_init(INI - 4);
    check(out_clocks_tied === 1'b0, "output clocks not used");
    for (int i = 0; i < 12; i++)
      req(1'(i % 3 == 0), addr[$urandom_range(7)], LN'($urandom()), LN'($urandom()));
    drain();
    give_verdict();
  end
endmodule // testbench
